// ---- common/dtc_params.svh ----
// Constants for the dual timer/counter block: offsets, fields, reset values.
// Assumes an 8-bit register port with one-cycle strobes and read data a cycle later.
//
// Function
// - 13-bit mode: 8-bit counter, divide-by-32 prescaler
// - 13-bit count: high byte plus low five bits
// - High byte steps on low bit four falling
// - High byte FFh to 00h wraps, sets overflow
// - Count gated by run and gate or pin
// - Select bit picks clock or count pin falls
// - Low byte advances on source falling edge
// - 13-bit count 1FFFh wraps to 0000h
// - 16-bit mode: both bytes one counter
// - FFFFh to 0000h sets overflow flag
// - Overflow interrupts only when enabled
// - Timer 1 toggle pin flips per overflow
// - Timer 0 toggle pin flips per overflow
// - Run bit set enables counting
// - Count bytes read/write, zero after reset
// - Run cleared stops and holds count
// - Timer ticks at clock/12 or clock/4
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_ADDR_T0_LOW    8'h8a
`define DTC_ADDR_T1_LOW    8'h8b
`define DTC_ADDR_T0_HIGH   8'h8c
`define DTC_ADDR_T1_HIGH   8'h8d
`define DTC_ADDR_PORT_TOG  8'h96
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_STATUS    8'h89
`define DTC_ADDR_MASK      8'h8e

`define DTC_BYTE_RESET     8'h00
`define DTC_TOG0_BIT       2
`define DTC_TOG1_BIT       3
`define DTC_LOW_TOP_BIT    4
`define DTC_LOW5_MASK      8'h1f
`define DTC_LOW5_MAX       8'h1f
`define DTC_BYTE_MAX       8'hff
// Control register: per timer [run, gate, select, mode]; timer 0 bits 3:0, timer 1 bits 7:4
`define DTC_CTL_RUN        0
`define DTC_CTL_GATE       1
`define DTC_CTL_SEL        2
`define DTC_CTL_MODE       3
`define DTC_CTL_STRIDE     4
`define DTC_PRESCALE_12    4'd11
`define DTC_PRESCALE_4     4'd3
`define DTC_PRESCALE_ZERO  4'd0

`endif

// ---- common/dtc_pkg.sv ----
// Types for the dual timer/counter block.
// Assumes dtc_params.svh supplies the numeric constants.
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b01,
    DTC_MODE_16 = 2'b10
  } dtc_mode_t;

  typedef struct packed {
    logic mode;
    logic sel;
    logic gate;
    logic run;
  } dtc_ctl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dtc_count_t;
endpackage

// ---- logic/dtc_timer.sv ----
// Two timer/counters in 13-bit and 16-bit modes with register port and interrupt.
// Assumes pins synchronous to mclk_in and a bus master that never waits.
//
// Chosen here: the strobed register port.
`include "dtc_params.svh"

module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       prescale_fast_in,
  input  wire logic [1:0] count_pin_in,
  input  wire logic [1:0] external_qualify_pin_in,
  output logic      [1:0] overflow_flag_out,
  output logic      [1:0] toggle_pin_out,
  output logic            irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  dtc_count_t cnt_q [2];
  dtc_ctl_t   ctl_q [2];
  logic [7:0] port_tog_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] tog_q;
  logic [1:0] pin_q;
  logic [3:0] pre_q;
  logic [7:0] rdata_q;
  logic       tick;
  logic [1:0] ovf;
  logic [1:0] stat_rd;

  assign stat_rd = {2{rd_in && clk_en_in && addr_in == `DTC_ADDR_STATUS}};

  ////////////////////////////////////////////////////////////////////////////
  // Internal clock prescaler
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pre_q <= `DTC_PRESCALE_ZERO;
    end else if (clk_en_in) begin
      if (tick) begin
        pre_q <= `DTC_PRESCALE_ZERO;
      end else begin
        pre_q <= pre_q + 4'd1;
      end
    end
  end
  assign tick = pre_q >= (prescale_fast_in ? `DTC_PRESCALE_4 : `DTC_PRESCALE_12);

  // Count pin history; a fall is counted in the cycle the pin is first seen low
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_q <= 2'b00;
    end else if (clk_en_in) begin
      pin_q <= count_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer counters
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic       src_fall;
    logic       en;
    logic       mode16;
    dtc_count_t nxt;
    logic       carry_hi;
    logic       wr_lo;
    logic       wr_hi;

    assign src_fall = ctl_q[i].sel ? (pin_q[i] && !count_pin_in[i]) : tick;
    assign en       = ctl_q[i].run && (!ctl_q[i].gate || external_qualify_pin_in[i])
                      && src_fall;
    assign mode16   = ctl_q[i].mode;
    assign wr_lo = wr_in && addr_in == (i == 0 ? `DTC_ADDR_T0_LOW : `DTC_ADDR_T1_LOW);
    assign wr_hi = wr_in && addr_in == (i == 0 ? `DTC_ADDR_T0_HIGH : `DTC_ADDR_T1_HIGH);

    always_comb begin
      nxt      = cnt_q[i];
      carry_hi = 1'b0;
      if (mode16) begin
        nxt      = cnt_q[i] + 16'd1;
        carry_hi = cnt_q[i] == {`DTC_BYTE_MAX, `DTC_BYTE_MAX};
      end else begin
        // Top three low bits kept but not counted
        nxt.low = (cnt_q[i].low & ~`DTC_LOW5_MASK) |
                  ((cnt_q[i].low + 8'd1) & `DTC_LOW5_MASK);
        if ((cnt_q[i].low & `DTC_LOW5_MASK) == `DTC_LOW5_MAX) begin
          nxt.high = cnt_q[i].high + 8'd1;
          carry_hi = cnt_q[i].high == `DTC_BYTE_MAX;
        end
      end
    end

    assign ovf[i] = en && carry_hi;

    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        cnt_q[i] <= {`DTC_BYTE_RESET, `DTC_BYTE_RESET};
      end else if (clk_en_in) begin
        if (en) begin
          cnt_q[i] <= nxt;
        end
        if (wr_lo) begin
          cnt_q[i].low <= wdata_in;
        end
        if (wr_hi) begin
          cnt_q[i].high <= wdata_in;
        end
      end
    end

    // Set wins over the read that clears
    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        status_q[i] <= 1'b0;
      end else if (clk_en_in) begin
        if (ovf[i]) begin
          status_q[i] <= 1'b1;
        end else if (stat_rd[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        tog_q[i] <= 1'b0;
      end else if (clk_en_in) begin
        if (ovf[i] && port_tog_q[i == 0 ? `DTC_TOG0_BIT : `DTC_TOG1_BIT]) begin
          tog_q[i] <= !tog_q[i];
        end
      end
    end

    always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
        ctl_q[i] <= '0;
      end else if (clk_en_in && wr_in && addr_in == `DTC_ADDR_CTRL) begin
        ctl_q[i] <= wdata_in[i*`DTC_CTL_STRIDE +: `DTC_CTL_STRIDE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      port_tog_q <= `DTC_BYTE_RESET;
      mask_q     <= 2'b00;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == `DTC_ADDR_PORT_TOG) begin
        port_tog_q <= wdata_in;
      end
      if (addr_in == `DTC_ADDR_MASK) begin
        mask_q <= wdata_in[1:0];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_q <= `DTC_BYTE_RESET;
    end else if (clk_en_in) begin
      rdata_q <= `DTC_BYTE_RESET;
      if (rd_in) begin
        case (addr_in)
          `DTC_ADDR_T0_LOW:   rdata_q <= cnt_q[0].low;
          `DTC_ADDR_T1_LOW:   rdata_q <= cnt_q[1].low;
          `DTC_ADDR_T0_HIGH:  rdata_q <= cnt_q[0].high;
          `DTC_ADDR_T1_HIGH:  rdata_q <= cnt_q[1].high;
          `DTC_ADDR_PORT_TOG: rdata_q <= port_tog_q;
          `DTC_ADDR_CTRL:     rdata_q <= {ctl_q[1], ctl_q[0]};
          `DTC_ADDR_STATUS:   rdata_q <= {6'h00, status_q};
          `DTC_ADDR_MASK:     rdata_q <= {6'h00, mask_q};
          default:            rdata_q <= `DTC_BYTE_RESET;
        endcase
      end
    end
  end

  assign rdata_out         = rdata_q;
  assign overflow_flag_out = status_q;
  assign toggle_pin_out    = tog_q;
  assign irq_out           = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_hold_when_idle: assert property (clk_en_in && !ctl_q[0].run && !wr_in |=>
    $stable(cnt_q[0])) else $error("timer 0 moved while stopped");
  a_ovf_sets_flag: assert property (clk_en_in && ovf[0] |=> status_q[0])
    else $error("overflow did not set flag");
  a_wrap_16: assert property (clk_en_in && ovf[1] && ctl_q[1].mode && !wr_in |=>
    cnt_q[1] == 16'h0000) else $error("16-bit wrap wrong");
  a_wrap_13: assert property (clk_en_in && ovf[0] && !ctl_q[0].mode && !wr_in |=>
    cnt_q[0].high == `DTC_BYTE_RESET && (cnt_q[0].low & `DTC_LOW5_MASK) == `DTC_BYTE_RESET)
    else $error("13-bit wrap");
  a_irq_masked: assert property (irq_out |-> |(status_q & mask_q))
    else $error("irq without enabled flag");
  a_toggle_flip: assert property (clk_en_in && ovf[1] && port_tog_q[`DTC_TOG1_BIT] |=>
    tog_q[1] != $past(tog_q[1])) else $error("timer 1 toggle missed");
  a_toggle_zero: assert property (clk_en_in && ovf[0] && port_tog_q[`DTC_TOG0_BIT] |=>
    tog_q[0] != $past(tog_q[0])) else $error("timer 0 toggle missed");
  a_write_wins: assert property (clk_en_in && wr_in && addr_in == `DTC_ADDR_T0_LOW |=>
    cnt_q[0].low == $past(wdata_in)) else $error("write lost to count");
  a_tick_spacing: assert property (clk_en_in && tick && !prescale_fast_in ##1
    (clk_en_in && !prescale_fast_in)[*8] |-> !tick) else $error("prescale too fast");
  a_high_step: assert property (clk_en_in && g_tmr[0].en && !ctl_q[0].mode && !wr_in
    && cnt_q[0].low[4:0] == 5'h1f |=> cnt_q[0].high == $past(cnt_q[0].high) + 8'd1)
    else $error("high byte not stepped");
  a_gate_blocks: assert property (clk_en_in && ctl_q[0].gate && !external_qualify_pin_in[0]
    && !wr_in |=> $stable(cnt_q[0])) else $error("timer 0 counted while gated off");

  c_ovf0: cover property (ovf[0]);
  c_ovf1_16: cover property (ovf[1] && ctl_q[1].mode);
  c_irq: cover property (irq_out);
  c_pin_count: cover property (g_tmr[1].en && ctl_q[1].sel);
  c_gate_open: cover property (g_tmr[0].en && ctl_q[0].gate);

endmodule

// ---- testbench/dtc_core_model.sv ----
// Processor core model: register port master for the timer block.
// Assumes a slave that answers every strobe with no wait.
module dtc_core_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge mclk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge mclk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the dual timer block.
// Assumes the core model as bus master and pins driven here.
`include "dtc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk_in  = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [1:0] count_pin_in = 2'b11;
  logic       clk_en        = 1'b1;
  logic       prescale_fast = 1'b1;
  logic [1:0] qual_pin      = 2'b00;
  logic [7:0] addr, wdata, rdata_out;
  logic       wr, rd, irq_out;
  logic [1:0] overflow_flag_out, toggle_pin_out;
  int         fail_count = 0;
  int         compares   = 0;
  always #2.5 mclk_in = ~mclk_in;
  dtc_core_model core (.mclk_in(mclk_in), .rdata_in(rdata_out), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  dtc_timer uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
    .prescale_fast_in(prescale_fast), .count_pin_in(count_pin_in),
    .external_qualify_pin_in(qual_pin),
    .overflow_flag_out(overflow_flag_out), .toggle_pin_out(toggle_pin_out), .irq_out(irq_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_flag(input int i);
    repeat (200) begin
      @(posedge mclk_in);
      #1;
      if (overflow_flag_out[i] === 1'b1) break;
    end
    chk({7'h0, overflow_flag_out[i]}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_rw();
    logic [7:0] d;
    logic [7:0] regs [5];
    regs = '{`DTC_ADDR_T0_LOW, `DTC_ADDR_T1_LOW, `DTC_ADDR_T0_HIGH, `DTC_ADDR_T1_HIGH,
      `DTC_ADDR_PORT_TOG};
    for (int i = 0; i < 5; i++) begin
      core.rd_reg(regs[i], d);
      chk(d, `DTC_BYTE_RESET);
      core.wr_reg(regs[i], 8'ha0 + 8'(i));
      core.rd_reg(regs[i], d);
      chk(d, 8'ha0 + 8'(i));
    end
    core.rd_reg(8'h70, d);
    chk(d, 8'h00);
  endtask
  task automatic t_ovf16();
    logic [7:0] d;
    core.wr_reg(`DTC_ADDR_T0_LOW, 8'hff);
    core.wr_reg(`DTC_ADDR_T0_HIGH, 8'hff);
    core.wr_reg(`DTC_ADDR_MASK, 8'h01);
    core.wr_reg(`DTC_ADDR_PORT_TOG, 8'h04);
    core.wr_reg(`DTC_ADDR_CTRL, 8'h09);
    wait_flag(0);
    chk({6'h0, irq_out, toggle_pin_out[0]}, 8'h03);
    core.rd_reg(`DTC_ADDR_T0_HIGH, d);
    chk(d, 8'h00);
    core.rd_reg(`DTC_ADDR_STATUS, d);
    chk(d, 8'h01);
    chk({7'h0, irq_out}, 8'h00);
  endtask
  // Timer 0 halted while timer 1 counts pin falls in 13-bit mode
  task automatic t_pin13();
    logic [7:0] h;
    logic [7:0] d;
    core.wr_reg(`DTC_ADDR_CTRL, 8'h50);
    core.rd_reg(`DTC_ADDR_T0_LOW, h);
    core.wr_reg(`DTC_ADDR_T1_LOW, 8'hff);
    core.wr_reg(`DTC_ADDR_T1_HIGH, 8'hff);
    core.wr_reg(`DTC_ADDR_PORT_TOG, 8'h08);
    repeat (20) @(posedge mclk_in);
    #1;
    chk({6'h0, overflow_flag_out}, 8'h00);
    @(posedge mclk_in);
    count_pin_in[1] <= 1'b0;
    wait_flag(1);
    chk({6'h0, irq_out, toggle_pin_out[1]}, 8'h01);
    core.rd_reg(`DTC_ADDR_T1_LOW, d);
    chk(d, 8'he0);
    core.rd_reg(`DTC_ADDR_T1_HIGH, d);
    chk(d, 8'h00);
    core.rd_reg(`DTC_ADDR_T0_LOW, d);
    chk(d, h);
  endtask
  // Timer 0 gated by its pin, then timed at the slow prescale
  task automatic t_gate_slow();
    logic [7:0] d;
    core.wr_reg(`DTC_ADDR_CTRL, 8'h00);
    core.wr_reg(`DTC_ADDR_T0_LOW, 8'h00);
    core.wr_reg(`DTC_ADDR_T0_HIGH, 8'h00);
    @(posedge mclk_in);
    prescale_fast <= 1'b0;
    core.wr_reg(`DTC_ADDR_CTRL, 8'h0b);
    repeat (60) @(posedge mclk_in);
    core.rd_reg(`DTC_ADDR_T0_LOW, d);
    chk(d, 8'h00);
    @(posedge mclk_in);
    qual_pin[0] <= 1'b1;
    repeat (120) @(posedge mclk_in);
    core.wr_reg(`DTC_ADDR_CTRL, 8'h00);
    core.rd_reg(`DTC_ADDR_T0_LOW, d);
    compares++;
    if (d < 8'd10 || d > 8'd11) begin
      fail_count++;
      $display("[FAIL] %0t slow prescale count %h", $time, d);
    end
    @(posedge mclk_in);
    qual_pin[0]   <= 1'b0;
    prescale_fast <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_reset_rw();
    t_ovf16();
    t_pin13();
    t_gate_slow();
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    fail_count++;
    complete_run();
  end
endmodule
